// >>> verilog/fbo_pkg.sv
`default_nettype none
package fbo_pkg;
	// ---------------------------------------------------------------
	// address map
	// ---------------------------------------------------------------
	localparam logic [31:0] FBO_FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] FBO_FLASH_END_512K = 32'h0007_FFFF;
	localparam logic [31:0] FBO_RAM_L0_BASE = 32'h0080_4000;
	localparam logic [31:0] FBO_RAM_L0_END = 32'h0080_5FFF;
	localparam logic [31:0] FBO_RAM_S_BASE = 32'h0080_6000;
	localparam logic [31:0] FBO_RAM_S_END = 32'h0080_7FFF;
	localparam logic [31:0] FBO_RAM_L1_BASE = 32'h0080_8000;
	localparam logic [31:0] FBO_RAM_L1_END = 32'h0080_9FFF;
	localparam int FBO_LBANK_BITS = 13;
	localparam int FBO_SBANK_BITS = 12;
	localparam int FBO_FLASH_KB = 512;
	// ---------------------------------------------------------------
	// register map (axi4-lite byte offsets)
	// ---------------------------------------------------------------
	localparam logic [7:0] FBO_REG_CTRL = 8'h00;
	localparam logic [7:0] FBO_REG_LSEL0 = 8'h04;
	localparam logic [7:0] FBO_REG_LSEL1 = 8'h08;
	localparam logic [7:0] FBO_REG_SSEL0 = 8'h0C;
	localparam logic [7:0] FBO_REG_SSEL1 = 8'h10;
	localparam logic [7:0] FBO_REG_STAT = 8'h14;
	localparam int FBO_CTRL_EN_BIT = 0;
	localparam logic [6:0] FBO_LSEL_RST = 7'h00;
	localparam logic [7:0] FBO_SSEL_RST = 8'h00;
	localparam logic [1:0] FBO_RESP_OKAY = 2'h0;
	localparam logic [1:0] FBO_RESP_SLVERR = 2'h2;
	// which window an access went to
	typedef enum logic [2:0]
	{
		FBO_HIT_NONE = 3'h0,
		FBO_HIT_L0 = 3'h1,
		FBO_HIT_S0 = 3'h2,
		FBO_HIT_S1 = 3'h3,
		FBO_HIT_L1 = 3'h4
	} fbo_hit_t;
endpackage : fbo_pkg
`default_nettype wire

// >>> verilog/fbo_sel_if.sv
`default_nettype none
interface fbo_sel_if;
	logic enable;
	logic [6:0] lsel0;
	logic [6:0] lsel1;
	logic [7:0] ssel0;
	logic [7:0] ssel1;
	modport regs (output enable, lsel0, lsel1, ssel0, ssel1);
	modport xlat (input enable, lsel0, lsel1, ssel0, ssel1);
endinterface : fbo_sel_if
`default_nettype wire

// >>> verilog/fbo_xlat.sv
`default_nettype none
module fbo_xlat
	import fbo_pkg::*;
#(
	parameter int FLASH_KB = FBO_FLASH_KB
)
(
	// selects
	fbo_sel_if.xlat sel,
	// address in and out
	input wire logic [31:0] cpu_addr,
	output logic [31:0] mem_addr,
	output fbo_pkg::fbo_hit_t hit
);
	// -----------------------------------------------------------------
	// combinational bank match
	// -----------------------------------------------------------------
	localparam logic [31:0] FLASH_LAST = 32'(FLASH_KB * 1024 - 1);
	logic in_flash;
	always_comb
	begin
		in_flash = (cpu_addr <= FLASH_LAST);
		hit = FBO_HIT_NONE;
		mem_addr = cpu_addr;
		// priority order settles a bank named twice
		if (sel.enable && in_flash)
		begin
			if (cpu_addr[18:13] == sel.lsel0[5:0] && !sel.lsel0[6])
			begin
				hit = FBO_HIT_L0;
				mem_addr = FBO_RAM_L0_BASE | {19'h0, cpu_addr[12:0]};
			end
			else if (cpu_addr[18:12] == sel.ssel0[6:0] && !sel.ssel0[7])
			begin
				hit = FBO_HIT_S0;
				mem_addr = FBO_RAM_S_BASE | {20'h0, cpu_addr[11:0]};
			end
			else if (cpu_addr[18:12] == sel.ssel1[6:0] && !sel.ssel1[7])
			begin
				hit = FBO_HIT_S1;
				mem_addr = (FBO_RAM_S_BASE + 32'h0000_1000) | {20'h0, cpu_addr[11:0]};
			end
			else if (cpu_addr[18:13] == sel.lsel1[5:0] && !sel.lsel1[6])
			begin
				hit = FBO_HIT_L1;
				mem_addr = FBO_RAM_L1_BASE | {19'h0, cpu_addr[12:0]};
			end
		end
	end
	// bank fields stop at address bit 18, so larger arrays cannot be served
	if (FLASH_KB != 512 && FLASH_KB != 384 && FLASH_KB != 256)
	begin : g_bad_size
		$error("unsupported flash size");
	end
endmodule : fbo_xlat
`default_nettype wire

// >>> verilog/fbo_top.sv
// Behaviour
// - flash split in 8K banks, two RAM windows
// - flash split in 4K banks, two RAM windows
// - priority large0, small0, small1, large1
// - large select 0 redirects to RAM
// - small selects redirect to their windows
// - RAM reachable at both addresses
// - match only inside flash size
//
// Chosen here: the address map and the AXI4-Lite slave port.
`default_nettype none
module fbo_top
	import fbo_pkg::*;
#(
	parameter int FLASH_KB = FBO_FLASH_KB
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// cpu access (one per cycle, valid qualifies)
	input wire logic cpu_valid,
	input wire logic [31:0] cpu_addr,
	output logic mem_valid,
	output logic [31:0] mem_addr,
	output logic mem_to_ram,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import fbo_pkg::*;
	fbo_sel_if sel ();
	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	logic en_r, en_nxt;
	logic [6:0] large_bank_select_0_r, large_bank_select_0_nxt;
	logic [6:0] large_bank_select_1_r, large_bank_select_1_nxt;
	logic [7:0] small_bank_select_0_r, small_bank_select_0_nxt;
	logic [7:0] small_bank_select_1_r, small_bank_select_1_nxt;
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0] aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt;
	logic [3:0] w_strb_r, w_strb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic mvalid_r, mvalid_nxt, mram_r, mram_nxt;
	logic [31:0] maddr_r, maddr_nxt;
	fbo_hit_t last_hit_r, last_hit_nxt;
	logic [31:0] xaddr;
	fbo_hit_t xhit;
	// merge a write lane by lane
	function automatic logic [31:0] fbo_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = new_v[i*8 +: 8];
		return res;
	endfunction : fbo_merge
	assign sel.enable = en_r;
	assign sel.lsel0 = large_bank_select_0_r;
	assign sel.lsel1 = large_bank_select_1_r;
	assign sel.ssel0 = small_bank_select_0_r;
	assign sel.ssel1 = small_bank_select_1_r;
	fbo_xlat #(.FLASH_KB(FLASH_KB)) u_xlat
	(
		.sel(sel),
		.cpu_addr(cpu_addr),
		.mem_addr(xaddr),
		.hit(xhit)
	);
	// -----------------------------------------------------------------
	// access path: one registered stage
	// -----------------------------------------------------------------
	// ram addresses fall through the translator untouched, so ram
	// stays reachable directly as well as through the flash alias
	always_comb
	begin
		mvalid_nxt = cpu_valid;
		maddr_nxt = xaddr;
		mram_nxt = cpu_valid && (xhit != FBO_HIT_NONE);
		last_hit_nxt = (cpu_valid && xhit != FBO_HIT_NONE) ? xhit : last_hit_r;
	end
	// -----------------------------------------------------------------
	// axi4-lite slave
	// -----------------------------------------------------------------
	// address and data may arrive in either order; response after both
	always_comb
	begin
		logic [31:0] wv;
		wv = 32'h0000_0000;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		aw_addr_nxt = aw_addr_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		awready_nxt = 1'b0;
		wready_nxt = 1'b0;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		en_nxt = en_r;
		large_bank_select_0_nxt = large_bank_select_0_r;
		large_bank_select_1_nxt = large_bank_select_1_r;
		small_bank_select_0_nxt = small_bank_select_0_r;
		small_bank_select_1_nxt = small_bank_select_1_r;
		arready_nxt = 1'b0;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_awvalid && awready_r)
		begin
			aw_got_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_got_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		awready_nxt = !aw_got_nxt && !bvalid_r && s_axi_awvalid && !awready_r;
		wready_nxt = !w_got_nxt && !bvalid_r && s_axi_wvalid && !wready_r;
		if (aw_got_r && w_got_r && !bvalid_r)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = FBO_RESP_OKAY;
			case (aw_addr_r)
				FBO_REG_CTRL:
				begin
					wv = fbo_merge({31'h0, en_r}, w_data_r, w_strb_r);
					en_nxt = wv[FBO_CTRL_EN_BIT];
				end
				FBO_REG_LSEL0:
				begin
					wv = fbo_merge({25'h0, large_bank_select_0_r}, w_data_r, w_strb_r);
					large_bank_select_0_nxt = wv[6:0];
				end
				FBO_REG_LSEL1:
				begin
					wv = fbo_merge({25'h0, large_bank_select_1_r}, w_data_r, w_strb_r);
					large_bank_select_1_nxt = wv[6:0];
				end
				FBO_REG_SSEL0:
				begin
					wv = fbo_merge({24'h0, small_bank_select_0_r}, w_data_r, w_strb_r);
					small_bank_select_0_nxt = wv[7:0];
				end
				FBO_REG_SSEL1:
				begin
					wv = fbo_merge({24'h0, small_bank_select_1_r}, w_data_r, w_strb_r);
					small_bank_select_1_nxt = wv[7:0];
				end
				FBO_REG_STAT: bresp_nxt = FBO_RESP_OKAY; // read-only, write ignored
				default: bresp_nxt = FBO_RESP_SLVERR;
			endcase
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
		// reads: one at a time, answered the cycle after acceptance
		if (s_axi_arvalid && arready_r)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = FBO_RESP_OKAY;
			case (s_axi_araddr)
				FBO_REG_CTRL: rdata_nxt = {31'h0, en_r};
				FBO_REG_LSEL0: rdata_nxt = {25'h0, large_bank_select_0_r};
				FBO_REG_LSEL1: rdata_nxt = {25'h0, large_bank_select_1_r};
				FBO_REG_SSEL0: rdata_nxt = {24'h0, small_bank_select_0_r};
				FBO_REG_SSEL1: rdata_nxt = {24'h0, small_bank_select_1_r};
				FBO_REG_STAT: rdata_nxt = {29'h0, last_hit_r};
				default:
				begin
					rdata_nxt = 32'h0000_0000;
					rresp_nxt = FBO_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
		arready_nxt = s_axi_arvalid && !arready_r && !rvalid_nxt;
	end
	// -----------------------------------------------------------------
	// state registers
	// -----------------------------------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			en_r <= 1'b0;
			large_bank_select_0_r <= FBO_LSEL_RST;
			large_bank_select_1_r <= FBO_LSEL_RST;
			small_bank_select_0_r <= FBO_SSEL_RST;
			small_bank_select_1_r <= FBO_SSEL_RST;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= FBO_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= FBO_RESP_OKAY;
			mvalid_r <= 1'b0;
			maddr_r <= 32'h0000_0000;
			mram_r <= 1'b0;
			last_hit_r <= FBO_HIT_NONE;
		end
		else
		begin
			en_r <= en_nxt;
			large_bank_select_0_r <= large_bank_select_0_nxt;
			large_bank_select_1_r <= large_bank_select_1_nxt;
			small_bank_select_0_r <= small_bank_select_0_nxt;
			small_bank_select_1_r <= small_bank_select_1_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			mvalid_r <= mvalid_nxt;
			maddr_r <= maddr_nxt;
			mram_r <= mram_nxt;
			last_hit_r <= last_hit_nxt;
		end
	end
	// outputs straight from flip-flops
	assign mem_valid = mvalid_r;
	assign mem_addr = maddr_r;
	assign mem_to_ram = mram_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule : fbo_top
`default_nettype wire

// >>> bench/fbo_checker_assertions.sv
`default_nettype none
module fbo_checker
	import fbo_pkg::*;
#(
	parameter int FLASH_KB = FBO_FLASH_KB
)
(
	// clock, reset, access path
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic cpu_valid,
	input wire logic [31:0] cpu_addr,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic mem_to_ram,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] FEND = FLASH_KB * 1024 - 1;
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// a hit is only meaningful for a qualified access
	a_access_latency: assert property (mem_valid == $past(cpu_valid)) else $error("latency");
	a_miss_unchanged: assert property (mem_valid && !mem_to_ram |->
		mem_addr == $past(cpu_addr)) else $error("miss changed address");
	a_hit_in_flash: assert property (mem_valid && mem_to_ram |->
		$past(cpu_addr) <= FEND) else $error("hit outside flash");
	a_hit_in_ram: assert property (mem_valid && mem_to_ram |->
		mem_addr inside {[FBO_RAM_L0_BASE:FBO_RAM_L1_END]}) else $error("hit outside ram");
	a_large_offset: assert property (mem_valid && mem_to_ram &&
		mem_addr[31:13] != FBO_RAM_S_BASE[31:13] |->
		mem_addr[12:0] == $past(cpu_addr[12:0])) else $error("large offset");
	a_small_offset: assert property (mem_valid && mem_to_ram &&
		mem_addr[31:13] == FBO_RAM_S_BASE[31:13] |->
		mem_addr[11:0] == $past(cpu_addr[11:0])) else $error("small offset");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_write_answer: assert property (s_wr_taken |-> ##[1:8] s_axi_bvalid) else $error("no bvalid");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("no rvalid");
endmodule : fbo_checker
bind fbo_top fbo_checker #(.FLASH_KB(FLASH_KB)) u_chk (.mclk, .reset_n, .cpu_valid, .cpu_addr,
	.mem_valid, .mem_addr, .mem_to_ram, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> bench/fbo_cpu_model.sv
`default_nettype none
module fbo_cpu_model
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// request from the bench
	input wire logic req,
	input wire logic [31:0] req_addr,
	// processor bus
	output logic cpu_valid,
	output logic [31:0] cpu_addr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic valid_nxt;
	logic [31:0] addr_nxt;
	// idle address flips each cycle so a stale value is never mistaken for a fetch
	always_comb
	begin
		valid_nxt = req;
		addr_nxt = req ? req_addr : ~cpu_addr;
	end
	// bus stays quiet at zero while in reset
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cpu_valid <= 1'b0;
			cpu_addr <= 32'h0;
		end
		else
		begin
			cpu_valid <= valid_nxt;
			cpu_addr <= addr_nxt;
		end
	end
endmodule : fbo_cpu_model
`default_nettype wire

// >>> bench/fbo_top_tb.sv
`default_nettype none
module fbo_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fbo_pkg::*;
	localparam logic [6:0] LOFF = 7'h40;
	localparam logic [7:0] SOFF = 8'h80;
	logic mclk = 1'b0;
	logic reset_n, cpu_valid, mem_valid, mem_to_ram, req;
	logic [31:0] cpu_addr, mem_addr, req_addr, s_axi_wdata, s_axi_rdata, rd;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [3:0] s_axi_wstrb;
	int err_total, num_checks;
	always #2.5 mclk = ~mclk;
	fbo_cpu_model u_cpu (.mclk, .reset_n, .req, .req_addr, .cpu_valid, .cpu_addr);
	fbo_top u_dut (.mclk, .reset_n, .cpu_valid, .cpu_addr, .mem_valid, .mem_addr, .mem_to_ram,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdr
	task automatic cfg(input logic [6:0] l0, l1, input logic [7:0] s0, s1);
		wr(FBO_REG_LSEL0, {25'h0, l0});
		wr(FBO_REG_LSEL1, {25'h0, l1});
		wr(FBO_REG_SSEL0, {24'h0, s0});
		wr(FBO_REG_SSEL1, {24'h0, s1});
		wr(FBO_REG_CTRL, 32'h1);
	endtask : cfg
	// model launches at one edge, the block answers one edge later
	task automatic acc(input logic [31:0] a, input logic [31:0] e, input logic r);
		@(posedge mclk);
		req <= 1'b1;
		req_addr <= a;
		@(posedge mclk);
		req <= 1'b0;
		@(posedge mclk);
		#1;
		check(mem_valid, 32'h1);
		check(mem_addr, e);
		check(mem_to_ram, r);
	endtask : acc
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] offs [6] = '{FBO_REG_CTRL, FBO_REG_LSEL0, FBO_REG_LSEL1, FBO_REG_SSEL0,
			FBO_REG_SSEL1, FBO_REG_STAT};
		foreach (offs[i])
		begin
			rdr(offs[i]);
			check(rd, 32'h0);
			check(rsp, FBO_RESP_OKAY);
		end
		wr(FBO_REG_SSEL1, 32'hFFFF_FFFF);
		rdr(FBO_REG_SSEL1);
		check(rd, 32'hFF);
		// lane 0 masked off, so the select must keep its value
		s_axi_wstrb <= 4'hE;
		wr(FBO_REG_SSEL1, 32'h0);
		s_axi_wstrb <= 4'hF;
		rdr(FBO_REG_SSEL1);
		check(rd, 32'hFF);
		// status is read-only: write answered but ignored
		wr(FBO_REG_STAT, 32'h7);
		check(rsp, FBO_RESP_OKAY);
		rdr(FBO_REG_STAT);
		check(rd, 32'h0);
		rdr(8'h18);
		check(rsp, FBO_RESP_SLVERR);
		check(rd, 32'h0);
		wr(8'h18, 32'h1);
		check(rsp, FBO_RESP_SLVERR);
	endtask : t_regs
	// select 0 with enable low must not redirect
	task automatic t_off;
		acc(32'h0000_1234, 32'h0000_1234, 1'b0);
	endtask : t_off
	task automatic t_map;
		cfg(7'h03, LOFF, SOFF, SOFF);
		acc(32'h0000_6ABC, 32'h0080_4ABC, 1'b1);
		acc(32'h0000_4ABC, 32'h0000_4ABC, 1'b0);
		acc(32'h0080_5000, 32'h0080_5000, 1'b0);
		cfg(7'h00, LOFF, SOFF, SOFF);
		acc(32'h0000_0010, 32'h0080_4010, 1'b1);
		acc(32'h0008_0010, 32'h0008_0010, 1'b0);
		cfg(LOFF, LOFF, 8'h05, 8'h7F);
		acc(32'h0000_5123, 32'h0080_6123, 1'b1);
		acc(32'h0007_FFFF, 32'h0080_7FFF, 1'b1);
	endtask : t_map
	// large selects name bank 2, small selects bank 4 (same address), drop the winner one at a time
	task automatic t_prio;
		logic [31:0] exp [4] = '{32'h0080_4010, 32'h0080_6010, 32'h0080_7010, 32'h0080_8010};
		for (int i = 0; i < 4; i++)
		begin
			cfg(i > 0 ? LOFF : 7'h02, 7'h02, i > 1 ? SOFF : 8'h04, i > 2 ? SOFF : 8'h04);
			acc(32'h0000_4010, exp[i], 1'b1);
		end
		rdr(FBO_REG_STAT);
		check(rd, {29'h0, FBO_HIT_L1});
		acc(32'h0080_8010, 32'h0080_8010, 1'b0);
		wr(FBO_REG_CTRL, 32'h0);
		acc(32'h0000_4010, 32'h0000_4010, 1'b0);
	endtask : t_prio
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		reset_n = 1'b0;
		req = 1'b0;
		req_addr = 32'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		t_off();
		t_regs();
		t_map();
		t_prio();
		end_of_test();
	end
	// the whole run needs well under ten thousand cycles
	initial
	begin
		#50000;
		err_total++;
		end_of_test();
	end
endmodule : fbo_top_tb
`default_nettype wire
